// ===== eir_pkg.sv
// Operation
// - each pin ORs its enabled event sources
// - pin A event route: bits 7,5,4,3
// - pin A state machine route, bit n-1
// - pin A learning route in bits 3:0
// - pin A master bit gates event routes
// - pin B event route mirrors pin A
// - pin B state machine route, bit n-1
// - pin B learning route in bits 3:0
// - pin B master bit gates event routes
// - all route bits reset to zero
// - event status reports pending, others zero
// - state machine status bit n-1 pending
// - status read-only, routes read/write
// - latch bit holds event and state machine requests until read
// - status read clears bits unmasked by ack
package eir_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int NUM_SM = 8;
   localparam int NUM_LC = 4;

   localparam logic [6:0] OFS_A_EVT = 7'h0A;
   localparam logic [6:0] OFS_A_SM = 7'h0B;
   localparam logic [6:0] OFS_A_LC = 7'h0D;
   localparam logic [6:0] OFS_B_EVT = 7'h0E;
   localparam logic [6:0] OFS_B_SM = 7'h0F;
   localparam logic [6:0] OFS_B_LC = 7'h11;
   localparam logic [6:0] OFS_EVT_STATUS = 7'h12;
   localparam logic [6:0] OFS_SM_STATUS = 7'h13;
   localparam logic [6:0] OFS_LATCH_CFG = 7'h17;
   localparam logic [6:0] OFS_ACK_MASK = 7'h4B;

   localparam int BIT_LONG_COUNT = 7;
   localparam int BIT_SIG_MOTION = 5;
   localparam int BIT_TILT = 4;
   localparam int BIT_STEP = 3;
   localparam int BIT_LATCH_EN = 7;
   localparam logic [7:0] EVT_USED_MASK = 8'hB8;
   localparam logic [7:0] LC_USED_MASK = 8'h0F;
   localparam logic [7:0] REG_RESET = 8'h00;

   // engine events, one per source
   typedef struct packed {
      logic long_count;
      logic sig_motion;
      logic tilt;
      logic step;
      logic [NUM_SM-1:0] sm;
      logic [NUM_LC-1:0] lc;
   } eir_events_t;

   // routing set belonging to one pin
   typedef struct packed {
      logic [7:0] evt;
      logic [7:0] sm;
      logic [7:0] lc;
   } eir_route_t;

   // register access strobes
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } eir_reg_req_t;
endpackage

// ===== eir_pin_router.sv
`timescale 1ns/1ps
module eir_pin_router #(
   parameter int N_SM = 8,
   parameter int N_LC = 4
) (
   input wire logic [7:0] i_evt_status,   // event status layout
   input wire logic [N_SM-1:0] i_sm_status, // state machine status
   input wire logic [N_LC-1:0] i_lc,      // learning decisions
   input wire logic [7:0] i_route_evt,    // event route register
   input wire logic [7:0] i_route_sm,     // state machine route register
   input wire logic [7:0] i_route_lc,     // learning route register
   input wire logic i_master,             // engine master route bit
   output logic o_irq                     // combined request
);
   import eir_pkg::*;

   // route registers are one byte wide, so wider counts cannot be served
   if (N_SM != 8 || N_LC != 4) begin : g_bad_count
      $error("router serves exactly 8 state machines and 4 learning outputs");
   end

   logic evt_hit;
   logic sm_hit;
   logic lc_hit;

   always_comb begin
      // unused route positions never contribute
      evt_hit = |(i_evt_status & i_route_evt & EVT_USED_MASK);
      sm_hit = |(i_sm_status & i_route_sm[N_SM-1:0]);
      lc_hit = |(i_lc & i_route_lc[N_LC-1:0]);
      // master bit gates engine and state machine routes only
      o_irq = (i_master & (evt_hit | sm_hit)) | lc_hit;
   end
endmodule

// ===== eir_irq_router.sv
`timescale 1ns/1ps
module eir_irq_router (
   input wire logic I_SYS_CLK,                  // device clock
   input wire logic I_RESETN,                   // async reset, active low
   input wire logic I_BANK_SEL,                 // engine register bank selected
   input wire eir_pkg::eir_reg_req_t I_REQ,     // register access
   input wire eir_pkg::eir_events_t I_EVENTS,   // live engine events
   input wire logic I_PIN_A_MASTER,             // engine master route, pin A
   input wire logic I_PIN_B_MASTER,             // engine master route, pin B
   output eir_pkg::eir_route_t O_ROUTE_A,       // pin A routing registers
   output eir_pkg::eir_route_t O_ROUTE_B,       // pin B routing registers
   output logic [7:0] O_RDATA,                  // read data
   output logic O_RVALID,                       // read data valid pulse
   output logic O_IRQ_PIN_A,                    // interrupt pin A
   output logic O_IRQ_PIN_B                     // interrupt pin B
);
   import eir_pkg::*;

   typedef struct packed {
      eir_route_t route_a;
      eir_route_t route_b;
      logic latch_en;
      logic [7:0] ack_mask;
      logic [7:0] evt_latched;
      logic [7:0] sm_latched;
      logic [7:0] rdata;
      logic rvalid;
      logic irq_a;
      logic irq_b;
   } eir_state_t;

   eir_state_t q;
   eir_state_t d;
   logic [7:0] evt_live;
   logic [7:0] evt_status;
   logic [7:0] sm_status;
   logic wr_ok;
   logic rd_ok;
   logic irq_a_c;
   logic irq_b_c;

   function automatic logic hit(input logic ok, input logic [6:0] a, input logic [6:0] ofs);
      hit = ok && (a == ofs);
   endfunction

   always_comb begin
      evt_live = 8'h00;
      evt_live[BIT_LONG_COUNT] = I_EVENTS.long_count;
      evt_live[BIT_SIG_MOTION] = I_EVENTS.sig_motion;
      evt_live[BIT_TILT] = I_EVENTS.tilt;
      evt_live[BIT_STEP] = I_EVENTS.step;
      // latched or live view
      evt_status = q.latch_en ? q.evt_latched : evt_live;
      sm_status = q.latch_en ? q.sm_latched : I_EVENTS.sm;
      wr_ok = I_REQ.wr & I_BANK_SEL;
      rd_ok = I_REQ.rd & I_BANK_SEL;
   end

   always_comb begin
      d = q;
      d.rvalid = rd_ok;
      d.irq_a = irq_a_c;
      d.irq_b = irq_b_c;
      // writes to status addresses fall through to nothing
      if (hit(wr_ok, I_REQ.addr, OFS_A_EVT)) begin
         d.route_a.evt = I_REQ.wdata;
      end
      if (hit(wr_ok, I_REQ.addr, OFS_A_SM)) begin
         d.route_a.sm = I_REQ.wdata;
      end
      if (hit(wr_ok, I_REQ.addr, OFS_A_LC)) begin
         d.route_a.lc = I_REQ.wdata;
      end
      if (hit(wr_ok, I_REQ.addr, OFS_B_EVT)) begin
         d.route_b.evt = I_REQ.wdata;
      end
      if (hit(wr_ok, I_REQ.addr, OFS_B_SM)) begin
         d.route_b.sm = I_REQ.wdata;
      end
      if (hit(wr_ok, I_REQ.addr, OFS_B_LC)) begin
         d.route_b.lc = I_REQ.wdata;
      end
      if (hit(wr_ok, I_REQ.addr, OFS_LATCH_CFG)) begin
         d.latch_en = I_REQ.wdata[BIT_LATCH_EN];
      end
      if (hit(wr_ok, I_REQ.addr, OFS_ACK_MASK)) begin
         d.ack_mask = I_REQ.wdata;
      end
      // read clears unmasked bits; new event in same cycle wins
      d.evt_latched = q.evt_latched;
      d.sm_latched = q.sm_latched;
      if (hit(rd_ok, I_REQ.addr, OFS_EVT_STATUS)) begin
         d.evt_latched = q.evt_latched & q.ack_mask;
      end
      if (hit(rd_ok, I_REQ.addr, OFS_SM_STATUS)) begin
         d.sm_latched = q.sm_latched & q.ack_mask;
      end
      if (q.latch_en) begin
         d.evt_latched = d.evt_latched | evt_live;
         d.sm_latched = d.sm_latched | I_EVENTS.sm;
      end else begin
         d.evt_latched = 8'h00;
         d.sm_latched = 8'h00;
      end
      d.rdata = 8'h00;
      if (rd_ok) begin
         case (I_REQ.addr)
            OFS_A_EVT: d.rdata = q.route_a.evt;
            OFS_A_SM: d.rdata = q.route_a.sm;
            OFS_A_LC: d.rdata = q.route_a.lc;
            OFS_B_EVT: d.rdata = q.route_b.evt;
            OFS_B_SM: d.rdata = q.route_b.sm;
            OFS_B_LC: d.rdata = q.route_b.lc;
            OFS_EVT_STATUS: d.rdata = evt_status & EVT_USED_MASK;
            OFS_SM_STATUS: d.rdata = sm_status;
            OFS_LATCH_CFG: d.rdata = {q.latch_en, 7'h00};
            OFS_ACK_MASK: d.rdata = q.ack_mask;
            default: d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         q.route_a <= '0;
         q.route_b <= '0;
         q.latch_en <= 1'b0;
         q.ack_mask <= REG_RESET;
         q.evt_latched <= 8'h00;
         q.sm_latched <= 8'h00;
         q.rdata <= 8'h00;
         q.rvalid <= 1'b0;
         q.irq_a <= 1'b0;
         q.irq_b <= 1'b0;
      end else begin
         q <= d;
      end
   end

   eir_pin_router #(.N_SM(NUM_SM), .N_LC(NUM_LC)) u_pin_a (
      .i_evt_status(evt_status),
      .i_sm_status(sm_status),
      .i_lc(I_EVENTS.lc),
      .i_route_evt(q.route_a.evt),
      .i_route_sm(q.route_a.sm),
      .i_route_lc(q.route_a.lc),
      .i_master(I_PIN_A_MASTER),
      .o_irq(irq_a_c)
   );

   eir_pin_router #(.N_SM(NUM_SM), .N_LC(NUM_LC)) u_pin_b (
      .i_evt_status(evt_status),
      .i_sm_status(sm_status),
      .i_lc(I_EVENTS.lc),
      .i_route_evt(q.route_b.evt),
      .i_route_sm(q.route_b.sm),
      .i_route_lc(q.route_b.lc),
      .i_master(I_PIN_B_MASTER),
      .o_irq(irq_b_c)
   );

   assign O_ROUTE_A = q.route_a;
   assign O_ROUTE_B = q.route_b;
   assign O_RDATA = q.rdata;
   assign O_RVALID = q.rvalid;
   assign O_IRQ_PIN_A = q.irq_a;
   assign O_IRQ_PIN_B = q.irq_b;
endmodule

// ===== eir_engine_model.sv
`timescale 1ns/1ps
module eir_engine_model
   import eir_pkg::*;
(
   input wire logic i_clk, // device clock
   input wire eir_pkg::eir_events_t i_next, // events to present
   output eir_pkg::eir_events_t o_events // live engine levels
);
   // levels change off the sampling edge
   always @(negedge i_clk) begin
      o_events <= i_next;
   end
endmodule

// ===== eir_irq_router_asserts.sv
`timescale 1ns/1ps
module eir_irq_router_asserts
   import eir_pkg::*;
(
   input wire logic I_SYS_CLK, // clock
   input wire logic I_RESETN, // reset
   input wire logic I_BANK_SEL, // bank
   input wire eir_pkg::eir_reg_req_t I_REQ, // access
   input wire eir_pkg::eir_events_t I_EVENTS, // events
   input wire logic I_PIN_A_MASTER, // master a
   input wire logic I_PIN_B_MASTER, // master b
   input wire eir_pkg::eir_route_t O_ROUTE_A, // routes a
   input wire eir_pkg::eir_route_t O_ROUTE_B, // routes b
   input wire logic [7:0] O_RDATA, // read data
   input wire logic O_RVALID, // read valid
   input wire logic O_IRQ_PIN_A, // pin a
   input wire logic O_IRQ_PIN_B // pin b
);
   wire logic [7:0] evt = {I_EVENTS.long_count, 1'b0, I_EVENTS.sig_motion, I_EVENTS.tilt,
      I_EVENTS.step, 3'b000};
   wire logic take = I_BANK_SEL && I_REQ.rd;
   wire logic put = I_BANK_SEL && I_REQ.wr;
   wire logic lc_a = |(I_EVENTS.lc & O_ROUTE_A.lc[3:0]);
   wire logic lc_b = |(I_EVENTS.lc & O_ROUTE_B.lc[3:0]);
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESETN);
   chk_read_answer: assert property (take |=> O_RVALID)
      else $error("read not answered");
   chk_no_stray: assert property (!take |=> !O_RVALID)
      else $error("stray read valid");
   chk_route_write: assert property (put && I_REQ.addr == OFS_B_SM |=>
      O_ROUTE_B.sm == $past(I_REQ.wdata)) else $error("route write lost");
   chk_route_hold: assert property (!put |=> $stable(O_ROUTE_A) && $stable(O_ROUTE_B))
      else $error("route changed without write");
   chk_pin_a_event: assert property (I_PIN_A_MASTER && |(evt & O_ROUTE_A.evt)
      |-> ##[1:2] O_IRQ_PIN_A) else $error("pin a missed event");
   chk_pin_b_sm: assert property (I_PIN_B_MASTER && |(I_EVENTS.sm & O_ROUTE_B.sm)
      |-> ##[1:2] O_IRQ_PIN_B) else $error("pin b missed state machine");
   chk_pin_a_lc: assert property (lc_a |-> ##[1:2] O_IRQ_PIN_A)
      else $error("pin a missed decision");
   chk_pin_a_gate: assert property (!I_PIN_A_MASTER && !lc_a |=> !O_IRQ_PIN_A)
      else $error("pin a ungated");
   chk_pin_b_gate: assert property (!I_PIN_B_MASTER && !lc_b |=> !O_IRQ_PIN_B)
      else $error("pin b ungated");
   cover property (take);
   cover property ($rose(O_IRQ_PIN_A));
   cover property ($rose(O_IRQ_PIN_B));
endmodule
bind eir_irq_router eir_irq_router_asserts eir_irq_router_asserts_inst (.I_SYS_CLK, .I_RESETN,
   .I_BANK_SEL, .I_REQ, .I_EVENTS, .I_PIN_A_MASTER, .I_PIN_B_MASTER, .O_ROUTE_A, .O_ROUTE_B,
   .O_RDATA, .O_RVALID, .O_IRQ_PIN_A, .O_IRQ_PIN_B);

// ===== test_eir_irq_router.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module test_eir_irq_router;
   import eir_pkg::*;
   logic clk = 0;
   logic rstn = 0;
   logic bank = 1;
   logic ma = 1;
   logic mb = 1;
   logic rvalid, pa, pb;
   logic [7:0] rdata;
   eir_reg_req_t req = '0;
   eir_events_t nxt = '0;
   eir_events_t evs, e;
   eir_route_t ra, rb;
   int num_errors = 0;
   int checks_done = 0;
   logic [6:0] ofs [6] = '{OFS_A_EVT, OFS_A_SM, OFS_A_LC, OFS_B_EVT, OFS_B_SM, OFS_B_LC};
   logic [7:0] msk [6] = '{EVT_USED_MASK, 8'hFF, LC_USED_MASK, EVT_USED_MASK, 8'hFF,
      LC_USED_MASK};
   logic [7:0] eb [4] = '{8'h80, 8'h20, 8'h10, 8'h08};
   always #2 clk = ~clk;
   eir_engine_model eir_engine_model_inst (.i_clk(clk), .i_next(nxt), .o_events(evs));
   eir_irq_router eir_irq_router_inst (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_BANK_SEL(bank),
      .I_REQ(req), .I_EVENTS(evs), .I_PIN_A_MASTER(ma), .I_PIN_B_MASTER(mb),
      .O_ROUTE_A(ra), .O_ROUTE_B(rb), .O_RDATA(rdata), .O_RVALID(rvalid),
      .O_IRQ_PIN_A(pa), .O_IRQ_PIN_B(pb));
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      req <= '{1'b1, 1'b0, a, d};
      @(negedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] x);
      @(negedge clk);
      req <= '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk);
      req <= '0;
      `CHK(rvalid, 1'b1)
      `CHK(rdata, x)
   endtask
   task automatic ev(input eir_events_t v);
      nxt <= v;
      repeat (4) @(negedge clk);
   endtask
   task automatic pins(input logic a, input logic b);
      `CHK(pa, a)
      `CHK(pb, b)
   endtask
   task automatic complete_run;
      if (num_errors == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge clk);
      num_errors++;
      complete_run;
   end
   initial begin
      repeat (20) @(negedge clk);
      rstn <= 1;
      `CHK(ra, 24'h0)
      `CHK(rb, 24'h0)
      foreach (ofs[i]) begin
         rd(ofs[i], 8'h00);
         wr(ofs[i], msk[i]);
         rd(ofs[i], msk[i]);
      end
      for (int k = 0; k < 4; k++) begin
         e = '0;
         {e.long_count, e.sig_motion, e.tilt, e.step} = {eb[k][7], eb[k][5:3]};
         wr(OFS_A_EVT, eb[k]);
         wr(OFS_B_EVT, EVT_USED_MASK ^ eb[k]);
         ev(e);
         pins(1'b1, 1'b0);
         rd(OFS_EVT_STATUS, eb[k]);
         rd(OFS_EVT_STATUS, eb[k]);
      end
      ma <= 0;
      ev(e);
      pins(1'b0, 1'b0);
      ma <= 1;
      for (int n = 0; n < 8; n++) begin
         e = '0;
         e.sm = 8'h01 << n;
         wr(OFS_A_SM, e.sm);
         wr(OFS_B_SM, ~e.sm);
         ev(e);
         pins(1'b1, 1'b0);
         rd(OFS_SM_STATUS, e.sm);
      end
      e.sm = 8'hFF;
      mb <= 0;
      ev(e);
      pins(1'b1, 1'b0);
      e = '0;
      e.lc = 4'h4;
      ma <= 0;
      wr(OFS_A_LC, 8'h04);
      wr(OFS_B_LC, 8'h0B);
      ev(e);
      pins(1'b1, 1'b0);
      ev('0);
      wr(OFS_EVT_STATUS, 8'hFF);
      rd(OFS_EVT_STATUS, 8'h00);
      rd(7'h0C, 8'h00);
      bank <= 0;
      wr(OFS_A_SM, 8'h00);
      bank <= 1;
      rd(OFS_A_SM, 8'h80);
      ma <= 1;
      wr(OFS_LATCH_CFG, 8'h80);
      wr(OFS_ACK_MASK, 8'h08);
      wr(OFS_A_EVT, 8'h18);
      e = '0;
      e.tilt = 1'b1;
      e.step = 1'b1;
      ev(e);
      ev('0);
      pins(1'b1, 1'b0);
      rd(OFS_EVT_STATUS, 8'h18);
      rd(OFS_EVT_STATUS, 8'h08);
      wr(OFS_ACK_MASK, 8'h00);
      rd(OFS_EVT_STATUS, 8'h08);
      rd(OFS_EVT_STATUS, 8'h00);
      e = '0;
      e.sm = 8'h01;
      ev(e);
      ev('0);
      rd(OFS_SM_STATUS, 8'h01);
      rd(OFS_SM_STATUS, 8'h00);
      ev('0);
      pins(1'b0, 1'b0);
      complete_run;
   end
endmodule
